/* File: hw/sdc_pkg.sv */
package sdc_pkg;

    // Register map on the plain register port
    localparam logic [11:0] ADDR_DATA    = 12'hf60;
    localparam logic [11:0] ADDR_CONTROL = 12'hf61;
    localparam logic [11:0] ADDR_STATE   = 12'hf62;

    // serial_control fields
    localparam int CTL_IRQ_EN   = 7;
    localparam int CTL_FORCE    = 6;
    localparam int CTL_TIMER_EN = 5;
    localparam int CTL_PHASE    = 4;
    localparam int CTL_POL      = 3;
    localparam int CTL_OPEN     = 2;
    localparam int CTL_MASTER   = 1;
    localparam int CTL_ENABLE   = 0;

    // serial_state fields
    localparam int ST_IRQ  = 7;
    localparam int ST_OVR  = 6;
    localparam int ST_COL  = 5;
    localparam int ST_ABT  = 4;
    localparam int ST_TRANSFER_ACTIVE = 1;
    localparam int ST_SELECT_PIN_STATE = 0;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATE_RESET   = 8'h01;
    localparam logic [7:0] DATA_RESET    = 8'h00;

    // character_length code 000 stands for a full byte
    localparam logic [2:0] LEN_CODE_FULL = 3'h0;
    localparam logic [3:0] LEN_FULL      = 4'h8;

    typedef enum logic {
        SDC_IDLE  = 1'b0,
        SDC_SHIFT = 1'b1
    } sdc_state_t;

    typedef struct packed {
        sdc_state_t st;
        logic [7:0] shreg;
        logic       out_bit;
        logic [3:0] bit_cnt;
        logic [4:0] edge_cnt;
        logic       sck_lvl;
        logic       prev_sck;
        logic       prev_ss_n;
        logic [7:0] ctl;
        logic       irq;
        logic       overrun_flag;
        logic       col;
        logic       slave_abort_flag;
        logic       select_pin_state;
        logic [7:0] rdata;
        logic       irq_out;
        logic       sck_o;
        logic       sck_oe;
        logic       ss_n_o;
        logic       ss_n_oe;
        logic       mosi_o;
        logic       mosi_oe;
        logic       miso_o;
        logic       miso_oe;
    } sdc_regs_t;

endpackage : sdc_pkg

/* File: hw/sdc_spi.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Data register reads return the live 8-bit shift register contents.
// - Shift out from bit 7; last received bit lands in bit 0.
// - In master role a data write starts a serial transfer.
// - In slave role a data write loads the shift register for the master.
// - Data write during a transfer is dropped and sets the overrun flag.
// - Short received characters end right-justified, last bit in bit 0.
// - Control bit 7 gates interrupt requests to the controller.
// - Writing 1 to control bit 6 sets pending flag and forces a request.
// - Writing 1 to the pending flag also clears the force-request bit.
// - Control bit 5 enables the timer interrupt only while disabled.
// - Control bit 4 selects clock phase between data and clock edges.
// - Control bit 3 sets serial clock idle level: 0 low, 1 high.
// - Control bit 2 makes all four serial pins open-drain.
// - Control bit 1 selects slave (0) or master (1) role.
// - Control bit 0 enables the block; all control bits reset to 0.
// - While disabled every status bit holds its reset value.
// - Status flags read back; writing 1 clears, writing 0 keeps.
// - Pending flag sets on force-request write, on character completion or on slave abort.
// - Timer timeout reaches the controller without setting the pending flag.
// - Status bit 6 shows a detected overrun until cleared by writing 1.
// - Character length code 000 is eight bits, others one to seven bits.
// - Enabled master sets collision flag when its select pin is low while it is not driving it.
// - Slave select release mid-character sets abort and pending flags.
module sdc_spi (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [2:0]  char_length_i,
    input  wire logic        ss_drive_i,
    input  wire logic        ss_value_i,
    input  wire logic        baud_tick_i,
    input  wire logic        baud_timeout_i,
    output logic             timer_enable_o,
    output logic             irq_o,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_o,
    input  wire logic        ss_n_i,
    output logic             ss_n_o,
    output logic             ss_n_oe_o,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_o,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_o
);

    sdc_pkg::sdc_regs_t r_reg;
    sdc_pkg::sdc_regs_t r_next;

    // Pin output value and enable; open-drain drives only a low level
    function automatic logic [1:0] pin_drive(input logic drive, input logic val,
                                             input logic open_drain);
        if (open_drain) begin
            pin_drive = {1'b0, drive & ~val};
        end else begin
            pin_drive = {val, drive};
        end
    endfunction : pin_drive

    ////////////////////////////////////////////////////////////////////////////////

    logic       en;
    logic       master;
    logic       pol;
    logic       phase;
    logic       od;
    logic [3:0] char_len;
    logic [4:0] edge_total;
    logic       wr_data;
    logic       wr_ctl;
    logic       wr_state;
    logic       active;
    logic       done_evt;
    logic       lead_edge;
    logic       trail_edge;
    logic       do_sample;
    logic       do_shift;
    logic       ss_asserted;

    assign en       = r_reg.ctl[sdc_pkg::CTL_ENABLE];
    assign master   = r_reg.ctl[sdc_pkg::CTL_MASTER];
    assign pol      = r_reg.ctl[sdc_pkg::CTL_POL];
    assign phase    = r_reg.ctl[sdc_pkg::CTL_PHASE];
    assign od       = r_reg.ctl[sdc_pkg::CTL_OPEN];
    assign wr_data  = wr_i && (addr_i == sdc_pkg::ADDR_DATA);
    assign wr_ctl   = wr_i && (addr_i == sdc_pkg::ADDR_CONTROL);
    assign wr_state = wr_i && (addr_i == sdc_pkg::ADDR_STATE);
    assign active   = (r_reg.st == sdc_pkg::SDC_SHIFT);

    // A full byte is encoded as 000
    assign char_len   = (char_length_i == sdc_pkg::LEN_CODE_FULL) ? sdc_pkg::LEN_FULL
                                                                 : {1'b0, char_length_i};
    assign edge_total = {char_len, 1'b0};

    assign ss_asserted = ~ss_n_i;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        r_next     = r_reg;
        done_evt   = 1'b0;
        lead_edge  = 1'b0;
        trail_edge = 1'b0;
        do_sample  = 1'b0;
        do_shift   = 1'b0;

        r_next.prev_sck  = sck_i;
        r_next.prev_ss_n = ss_n_i;

        // Control register; the force bit is only ever set by a write
        if (wr_ctl) begin
            r_next.ctl = wdata_i;
            r_next.ctl[sdc_pkg::CTL_FORCE] = r_reg.ctl[sdc_pkg::CTL_FORCE]
                                           | wdata_i[sdc_pkg::CTL_FORCE];
        end
        if (wr_state && wdata_i[sdc_pkg::ST_IRQ]) begin
            r_next.ctl[sdc_pkg::CTL_FORCE] = 1'b0;
        end

        // Write-1-to-clear flags; events below override the clear
        if (wr_state) begin
            if (wdata_i[sdc_pkg::ST_IRQ]) r_next.irq = 1'b0;
            if (wdata_i[sdc_pkg::ST_OVR]) r_next.overrun_flag = 1'b0;
            if (wdata_i[sdc_pkg::ST_COL]) r_next.col = 1'b0;
            if (wdata_i[sdc_pkg::ST_ABT]) r_next.slave_abort_flag = 1'b0;
        end

        // Data register writes
        if (wr_data) begin
            if (active && en) begin
                r_next.overrun_flag = 1'b1;
            end else begin
                r_next.shreg   = wdata_i;
                r_next.out_bit = wdata_i[7];
                if (en && master) begin
                    r_next.st       = sdc_pkg::SDC_SHIFT;
                    r_next.bit_cnt  = '0;
                    r_next.edge_cnt = '0;
                    r_next.sck_lvl  = pol;
                end
            end
        end

        if (en && master) begin
            // Master: each baud tick is one clock edge, two per bit
            if (active && baud_tick_i) begin
                r_next.sck_lvl = ~r_reg.sck_lvl;
                lead_edge      = ~r_reg.edge_cnt[0];
                trail_edge     = r_reg.edge_cnt[0];
                r_next.edge_cnt = r_reg.edge_cnt + 5'h01;
                if (r_next.edge_cnt == edge_total) begin
                    r_next.st = sdc_pkg::SDC_IDLE;
                    done_evt  = 1'b1;
                end
            end else if (!active) begin
                r_next.sck_lvl = pol;
            end
            // Another master pulls our select low
            if (!ss_drive_i && ss_asserted) begin
                r_next.col = 1'b1;
            end
        end else if (en) begin
            // Slave: edges taken from the pin against the previous sample
            lead_edge  = ss_asserted && (r_reg.prev_sck == pol) && (sck_i != pol);
            trail_edge = ss_asserted && (r_reg.prev_sck != pol) && (sck_i == pol);
            if (ss_asserted && r_reg.prev_ss_n) begin
                // Fresh selection restarts the character from bit 7
                r_next.bit_cnt = '0;
                r_next.out_bit = r_reg.shreg[7];
            end
            if (!active && lead_edge) begin
                r_next.st      = sdc_pkg::SDC_SHIFT;
                r_next.bit_cnt = '0;
            end
            if (active && !ss_asserted) begin
                r_next.st  = sdc_pkg::SDC_IDLE;
                r_next.slave_abort_flag = 1'b1;
                r_next.irq = 1'b1;
            end
        end

        // Phase 0 samples on the leading edge, phase 1 on the trailing edge
        do_sample = (phase ? trail_edge : lead_edge) && (active || lead_edge);
        do_shift  = (phase ? lead_edge : trail_edge);

        if (en && do_sample && (active || !master)) begin
            r_next.shreg   = {r_reg.shreg[6:0], master ? miso_i : mosi_i};
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
            if (!master && (r_next.bit_cnt == char_len)) begin
                r_next.st      = sdc_pkg::SDC_IDLE;
                r_next.bit_cnt = '0;
                done_evt       = 1'b1;
            end
        end else if (en && do_shift && (active || !master)) begin
            r_next.out_bit = r_reg.shreg[7];
        end

        if (done_evt) begin
            r_next.irq = 1'b1;
        end
        if (wr_ctl && wdata_i[sdc_pkg::CTL_FORCE]) begin
            r_next.irq = 1'b1;
        end

        r_next.select_pin_state = master ? 1'b1 : ss_n_i;

        // Disabled: status back to reset, no transfer in flight
        if (!en) begin
            r_next.st       = sdc_pkg::SDC_IDLE;
            r_next.irq      = sdc_pkg::STATE_RESET[sdc_pkg::ST_IRQ];
            r_next.overrun_flag      = sdc_pkg::STATE_RESET[sdc_pkg::ST_OVR];
            r_next.col      = sdc_pkg::STATE_RESET[sdc_pkg::ST_COL];
            r_next.slave_abort_flag      = sdc_pkg::STATE_RESET[sdc_pkg::ST_ABT];
            r_next.select_pin_state     = sdc_pkg::STATE_RESET[sdc_pkg::ST_SELECT_PIN_STATE];
            r_next.bit_cnt  = '0;
            r_next.edge_cnt = '0;
            r_next.sck_lvl  = pol;
        end

        // Timer timeout is a pulse straight to the controller, no flag
        if (en) begin
            r_next.irq_out = r_reg.irq && r_reg.ctl[sdc_pkg::CTL_IRQ_EN];
        end else begin
            r_next.irq_out = baud_timeout_i && r_reg.ctl[sdc_pkg::CTL_TIMER_EN]
                             && r_reg.ctl[sdc_pkg::CTL_IRQ_EN];
        end
        if (!r_reg.ctl[sdc_pkg::CTL_IRQ_EN]) begin
            r_next.irq_out = 1'b0;
        end

        // Pins, registered so every output comes from a flip-flop
        {r_next.sck_o, r_next.sck_oe}   = pin_drive(en && master, r_next.sck_lvl, od);
        {r_next.mosi_o, r_next.mosi_oe} = pin_drive(en && master, r_next.out_bit, od);
        {r_next.miso_o, r_next.miso_oe} = pin_drive(en && !master && ss_asserted,
                                                    r_next.out_bit, od);
        {r_next.ss_n_o, r_next.ss_n_oe} = pin_drive(en && master && ss_drive_i,
                                                    ss_value_i, od);

        // Read data one cycle after the read strobe; unmapped reads give zero
        r_next.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                sdc_pkg::ADDR_DATA: begin
                    r_next.rdata = r_reg.shreg;
                end
                sdc_pkg::ADDR_CONTROL: begin
                    r_next.rdata = r_reg.ctl;
                end
                sdc_pkg::ADDR_STATE: begin
                    r_next.rdata[sdc_pkg::ST_IRQ]  = r_reg.irq;
                    r_next.rdata[sdc_pkg::ST_OVR]  = r_reg.overrun_flag;
                    r_next.rdata[sdc_pkg::ST_COL]  = r_reg.col;
                    r_next.rdata[sdc_pkg::ST_ABT]  = r_reg.slave_abort_flag;
                    r_next.rdata[sdc_pkg::ST_TRANSFER_ACTIVE] = active;
                    r_next.rdata[sdc_pkg::ST_SELECT_PIN_STATE] = r_reg.select_pin_state;
                end
                default: begin
                    r_next.rdata = 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r_reg           <= '0;
            r_reg.st        <= sdc_pkg::SDC_IDLE;
            r_reg.shreg     <= sdc_pkg::DATA_RESET;
            r_reg.ctl       <= sdc_pkg::CONTROL_RESET;
            r_reg.select_pin_state      <= sdc_pkg::STATE_RESET[sdc_pkg::ST_SELECT_PIN_STATE];
            r_reg.prev_ss_n <= 1'b1;
            r_reg.ss_n_o    <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata_o        = r_reg.rdata;
    assign irq_o          = r_reg.irq_out;
    assign sck_o          = r_reg.sck_o;
    assign sck_oe_o       = r_reg.sck_oe;
    assign ss_n_o         = r_reg.ss_n_o;
    assign ss_n_oe_o      = r_reg.ss_n_oe;
    assign mosi_o         = r_reg.mosi_o;
    assign mosi_oe_o      = r_reg.mosi_oe;
    assign miso_o         = r_reg.miso_o;
    assign miso_oe_o      = r_reg.miso_oe;
    // Timer runs only while the block is off; ignored when enabled
    assign timer_enable_o = ~en & r_reg.ctl[sdc_pkg::CTL_TIMER_EN];

endmodule : sdc_spi

`default_nettype wire

/* File: test/sdc_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdc_slave_model (
    input  wire logic       sck_i,
    input  wire logic       ss_n_i,
    input  wire logic       mosi_i,
    input  wire logic [7:0] tx_i,
    output logic            miso_o,
    output logic      [7:0] rx_o
);
    logic [7:0] shreg;
    initial begin
        shreg = 8'h00;
        rx_o = 8'h00;
        miso_o = 1'b1;
    end
    // Mode 0 slave: reload on select, capture on rising, shift on falling
    always @(negedge ss_n_i) begin
        shreg = tx_i;
        miso_o = tx_i[7];
    end
    // Released line must not keep the last bit, or a late sample would pass
    always @(posedge ss_n_i) miso_o = ~miso_o;
    always @(posedge sck_i) if (!ss_n_i) rx_o = {rx_o[6:0], mosi_i};
    always @(negedge sck_i) begin
        if (!ss_n_i) begin
            shreg = {shreg[6:0], 1'b0};
            miso_o = shreg[7];
        end
    end
endmodule : sdc_slave_model
`default_nettype wire

/* File: test/sdc_spi_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sdc_spi_checker (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic [11:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        baud_tick_i,
    input wire logic        timer_enable_o,
    input wire logic        irq_o,
    input wire logic        sck_o,
    input wire logic        ss_n_i,
    input wire logic        ss_n_o,
    input wire logic        mosi_o,
    input wire logic        mosi_oe_o,
    input wire logic        miso_o,
    input wire logic        miso_oe_o
);
    logic [7:0] ctl_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Shadow of the control register; a 0 written to bit 6 keeps it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_q <= 8'h00;
        end else if (wr_i && addr_i == sdc_pkg::ADDR_CONTROL) begin
            ctl_q <= {wdata_i[7], wdata_i[6] | ctl_q[6], wdata_i[5:0]};
        end else if (wr_i && addr_i == sdc_pkg::ADDR_STATE && wdata_i[7]) begin
            ctl_q[6] <= 1'b0;
        end
    end
    a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    a_unmapped_read: assert property ($past(rd_i) && ($past(addr_i) < 12'hf60
        || $past(addr_i) > 12'hf62) |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_control_readback: assert property ($past(rd_i) && $past(addr_i) == 12'hf61
        |-> rdata_o == $past(ctl_q)) else $error("control readback wrong");
    a_state_disabled: assert property ($past(rd_i) && $past(addr_i) == 12'hf62
        && !$past(ctl_q[0]) && !$past(ctl_q[0], 2) |-> rdata_o == 8'h01)
        else $error("status not at reset value while disabled");
    a_state_reserved: assert property ($past(rd_i) && $past(addr_i) == 12'hf62
        |-> rdata_o[3:2] == 2'b00) else $error("reserved status bits set");
    a_irq_gate: assert property (!ctl_q[7] && !$past(ctl_q[7]) |-> !irq_o)
        else $error("interrupt raised while gated off");
    a_timer_enable: assert property (timer_enable_o == (!ctl_q[0] && ctl_q[5]))
        else $error("timer enable wrong");
    a_open_drain: assert property (ctl_q[2] && $past(ctl_q[2])
        |-> !sck_o && !ss_n_o && !mosi_o && !miso_o) else $error("open drain drives high");
    a_sck_still: assert property (!$past(baud_tick_i) && !$past(baud_tick_i, 2)
        && !$past(wr_i) && !$past(wr_i, 2) |-> $stable(sck_o)) else $error("clock moved");
    a_miso_released: assert property (ss_n_i && $past(ss_n_i) |-> !miso_oe_o)
        else $error("data out driven while not selected");
    c_irq: cover property ($rose(irq_o));
    c_timer: cover property (timer_enable_o);
    c_mosi: cover property (mosi_oe_o && mosi_o);
endmodule : sdc_spi_checker
bind sdc_spi sdc_spi_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .baud_tick_i(baud_tick_i),
    .timer_enable_o(timer_enable_o), .irq_o(irq_o), .sck_o(sck_o), .ss_n_i(ss_n_i),
    .ss_n_o(ss_n_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o));
`default_nettype wire

/* File: test/spi_data_control_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_data_control_status_bench;
    logic clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, baud_timeout_i = 1'b0;
    logic ss_drive_i = 1'b1, ss_value_i = 1'b1, baud_tick_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [7:0] wdata_i = 8'h00, rv, tx = 8'h00;
    logic [2:0] char_length_i = 3'h0;
    logic [1:0] tick_cnt = 2'h0;
    logic seen;
    logic m_sck = 1'b0, m_ss = 1'b1, m_mosi = 1'b1;
    wire logic [7:0] rdata_o, rx;
    wire logic timer_enable_o, irq_o, sck_o, sck_oe_o, ss_n_o, ss_n_oe_o, mosi_o, mosi_oe_o;
    wire logic miso_o, miso_oe_o, s_miso;
    // Idle bench master leaves the pull levels: clock low, select and data high
    wire logic sck_w = sck_oe_o ? sck_o : m_sck;
    wire logic ss_w = ss_n_oe_o ? ss_n_o : m_ss;
    wire logic mosi_w = mosi_oe_o ? mosi_o : m_mosi;
    wire logic miso_w = miso_oe_o ? miso_o : s_miso;
    int errors = 0;
    int checks = 0;
    sdc_spi dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .char_length_i(char_length_i),
        .ss_drive_i(ss_drive_i), .ss_value_i(ss_value_i), .baud_tick_i(baud_tick_i),
        .baud_timeout_i(baud_timeout_i), .timer_enable_o(timer_enable_o), .irq_o(irq_o),
        .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
        .ss_n_oe_o(ss_n_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o));
    sdc_slave_model partner (.sck_i(sck_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .tx_i(tx),
        .miso_o(s_miso), .rx_o(rx));
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        tick_cnt <= tick_cnt + 2'h1;
        baud_tick_i <= (tick_cnt == 2'h3);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : bus_rd
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic final_report;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // Polls the pending flag; a character takes at most 2*8 ticks of 4 cycles
    task automatic wait_done;
        rv = 8'h00;
        for (int i = 0; i < 60 && !rv[7]; i++) bus_rd(sdc_pkg::ADDR_STATE, rv);
    endtask : wait_done
    task automatic reselect(input logic [7:0] t);
        tx = t;
        ss_value_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        ss_value_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : reselect
    // Bench as far master, clock idling low; phase 1 moves data on the leading edge
    task automatic ext_byte(input logic [7:0] t, input int n, input logic p,
                            output logic [7:0] got);
        got = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            if (!p) m_mosi <= t[i];
            repeat (4) @(posedge clk_i);
            if (!p) got = {got[6:0], miso_w};
            m_sck <= 1'b1;
            if (p) m_mosi <= t[i];
            repeat (4) @(posedge clk_i);
            if (p) got = {got[6:0], miso_w};
            m_sck <= 1'b0;
        end
    endtask : ext_byte
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        bus_rd(sdc_pkg::ADDR_CONTROL, rv); check("control", rv, 8'h00);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("state", rv, 8'h01);
        bus_rd(12'hf63, rv); check("unmapped", rv, 8'h00);
    endtask : test_reset
    task automatic test_master_overrun;
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h83);
        reselect(8'h3c);
        bus_wr(sdc_pkg::ADDR_DATA, 8'ha5);
        bus_wr(sdc_pkg::ADDR_DATA, 8'hff);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("state busy", rv, 8'h43);
        wait_done();
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("state done", rv, 8'hc1);
        check("irq", {7'h0, irq_o}, 8'h01);
        bus_rd(sdc_pkg::ADDR_DATA, rv); check("data rx", rv, 8'h3c);
        check("partner rx", rx, 8'ha5);
        bus_wr(sdc_pkg::ADDR_STATE, 8'h40);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("state ovr clr", rv, 8'h81);
        bus_wr(sdc_pkg::ADDR_STATE, 8'h80);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("state clr", rv, 8'h01);
        check("irq clr", {7'h0, irq_o}, 8'h00);
    endtask : test_master_overrun
    task automatic test_short_char;
        char_length_i <= 3'h4;
        reselect(8'hd0);
        bus_wr(sdc_pkg::ADDR_DATA, 8'hb0);
        wait_done();
        bus_rd(sdc_pkg::ADDR_DATA, rv); check("short rx", {4'h0, rv[3:0]}, 8'h0d);
        check("partner short", {4'h0, rx[3:0]}, 8'h0b);
        bus_wr(sdc_pkg::ADDR_STATE, 8'h80);
        char_length_i <= 3'h0;
    endtask : test_short_char
    task automatic test_force;
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h43);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("forced", rv, 8'h81);
        check("irq gated", {7'h0, irq_o}, 8'h00);
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h83);
        bus_rd(sdc_pkg::ADDR_CONTROL, rv); check("force kept", rv, 8'hc3);
        check("irq on", {7'h0, irq_o}, 8'h01);
        bus_wr(sdc_pkg::ADDR_STATE, 8'h80);
        bus_rd(sdc_pkg::ADDR_CONTROL, rv); check("force clr", rv, 8'h83);
    endtask : test_force
    task automatic test_slave;
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h81);
        bus_wr(sdc_pkg::ADDR_DATA, 8'h96);
        m_ss <= 1'b0;
        ext_byte(8'h69, 8, 1'b0, rv); check("slave miso", rv, 8'h96);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("slave done", rv, 8'h80);
        bus_rd(sdc_pkg::ADDR_DATA, rv); check("slave rx", rv, 8'h69);
        @(posedge clk_i);
        m_ss <= 1'b1;
        bus_wr(sdc_pkg::ADDR_STATE, 8'h80);
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h91);
        bus_wr(sdc_pkg::ADDR_DATA, 8'hc3);
        m_ss <= 1'b0;
        ext_byte(8'h5a, 3, 1'b1, rv); check("phase1 miso", rv, 8'h06);
        bus_rd(sdc_pkg::ADDR_DATA, rv); check("phase1 rx", rv, 8'h1a);
        @(posedge clk_i);
        m_ss <= 1'b1;
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("abort", rv, 8'h91);
        bus_wr(sdc_pkg::ADDR_STATE, 8'h90);
    endtask : test_slave
    task automatic test_collision;
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h8b);
        ss_drive_i <= 1'b0;
        m_ss <= 1'b0;
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("collision", rv, 8'h21);
        check("sck idle high", {7'h0, sck_o}, 8'h01);
        @(posedge clk_i);
        ss_drive_i <= 1'b1;
        m_ss <= 1'b1;
        bus_wr(sdc_pkg::ADDR_STATE, 8'h20);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("col clr", rv, 8'h01);
    endtask : test_collision
    task automatic test_disable_timer;
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h43);
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'ha0);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("state off", rv, 8'h01);
        check("timer en", {7'h0, timer_enable_o}, 8'h01);
        @(posedge clk_i) baud_timeout_i <= 1'b1;
        seen = 1'b0;
        // The request is a one-cycle pulse: watch from the edge that drops the timeout
        repeat (3) begin
            @(posedge clk_i) baud_timeout_i <= 1'b0;
            #1 seen = seen | (irq_o === 1'b1);
        end
        check("timer irq", {7'h0, seen}, 8'h01);
        bus_rd(sdc_pkg::ADDR_STATE, rv); check("no pending", rv, 8'h01);
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'ha1);
        #1 check("timer ignored", {7'h0, timer_enable_o}, 8'h00);
        // Open-drain master idle, watched by the checker
        bus_wr(sdc_pkg::ADDR_CONTROL, 8'h07);
        repeat (4) @(posedge clk_i);
    endtask : test_disable_timer
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        test_reset();
        test_master_overrun();
        test_short_char();
        test_force();
        test_slave();
        test_collision();
        test_disable_timer();
        final_report();
    end
    initial begin
        #(25 * 20000);
        errors++;
        final_report();
    end
endmodule : spi_data_control_status_bench
`default_nettype wire
